// file: event_timer_defs.svh
`ifndef EVENT_TIMER_DEFS_SVH
`define EVENT_TIMER_DEFS_SVH
// ==========================================
// register byte offsets
`define OFF_COUNT      12'h000
`define OFF_CMP_A      12'h004
`define OFF_CMP_B      12'h008
`define OFF_CTRL0      12'h00c
`define OFF_FLAGS      12'h010
`define OFF_CTRL1      12'h014
// ==========================================
// reset values
`define RST_COUNT      8'h00
`define RST_CMP        8'hff
`define RST_CTRL0      8'h00
`define RST_FLAGS      8'h00
`define RST_CTRL1      8'h00
// ==========================================
// fields of control zero
`define C0_IEB         7
`define C0_IEA         6
`define C0_IEO         5
`define C0_CLR_HI      4
`define C0_CLR_LO      3
// ==========================================
// fields of flags/output register
`define FL_MB          7
`define FL_MA          6
`define FL_OV          5
`define FL_RSV_ONE     8'h10
// ==========================================
// fields of control one
`define C1_EDGE_HI     4
`define C1_EDGE_LO     3
`define C1_TRIGGER_START_ENABLE        2
`define C1_RSV_ONES    8'he0
// ==========================================
// prescaler span: longest divide is 128
`define PRE_WIDTH      7
`endif

// file: event_timer_pkg.sv
package event_timer_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    RUN_IDLE  = 4'b0001,
    RUN_COUNT = 4'b0010,
    RUN_HALT  = 4'b0100,
    RUN_WAIT  = 4'b1000
  } run_state_t;
endpackage

// file: event_timer_compare.sv
`timescale 1ns/10ps
`default_nettype none
`include "event_timer_defs.svh"

// Operation
// - count register is eight-bit up-counter advancing on each selected clock edge
// - cpu may read or write count anytime; write replaces count
// - count overflow sets overflow flag
// - count register resets to zero
// - two eight-bit compare registers a and b reset to all ones
// - compare a equal to count sets match flag a
// - compare b equal to count sets match flag b
// - compare a suppressed while compare a is being written
// - match flag a requests interrupt when enable bit 6 set
// - match flag b requests interrupt when enable bit 7 set
// - overflow flag requests interrupt when enable bit 5 set
// - clear field 00 none, 01 match a, 10 match b
// - clear field 11 clears on rising edge of clear pin
// - trigger enable set makes counter halt when cleared
// - internal clocks divide 4 to 128, chosen with extra select bit
// - select 000 or 100 stops counting
// - external clock rising 101, falling 110, both 111
// - trigger pin edge may start counting, rising, falling or both
// - output pin driven by matches per four output-select bits
// - per-match action 00 hold, 01 low, 10 high, 11 toggle
// - output pin is zero after reset until first match
// - flag clears only after reading one then writing zero
// - trigger enable starts on trigger edge, halts on match clear
module event_timer_compare
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_clock_pin,
  input  wire logic              ext_clear_pin,
  input  wire logic              start_trigger_pin,
  output logic                   wave_out_pin,
  output logic                   irq_request
);
  import event_timer_pkg::*;

  // ==========================================
  // bus decode
  logic       wr_acc;
  logic       rd_acc;
  logic       addr_ok;
  byte_t      wbyte;

  assign wr_acc  = psel & penable & pwrite;
  // reads captured at setup so data and seen mask agree
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign wbyte   = pwdata[7:0];
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `OFF_COUNT) || (paddr == `OFF_CMP_A) ||
                   (paddr == `OFF_CMP_B) || (paddr == `OFF_CTRL0) ||
                   (paddr == `OFF_FLAGS) || (paddr == `OFF_CTRL1);
  assign pslverr = psel & penable & ~addr_ok;

  // ==========================================
  // registers
  byte_t      count_value;
  byte_t      compare_value_a;
  byte_t      compare_value_b;
  byte_t      timer_control_zero;
  byte_t      timer_control_one;
  logic [3:0] out_sel;
  logic       overflow_flag;
  logic       match_a_flag;
  logic       match_b_flag;
  logic [2:0] flag_seen;

  logic [1:0] clear_sel;
  logic [2:0] clk_sel;
  logic       internal_clock_extra_select;
  logic [1:0] trig_edge;
  logic       trigger_start_enable;

  assign clear_sel = timer_control_zero[`C0_CLR_HI:`C0_CLR_LO];
  assign clk_sel   = timer_control_zero[2:0];
  assign internal_clock_extra_select = timer_control_one[0];
  assign trig_edge = timer_control_one[`C1_EDGE_HI:`C1_EDGE_LO];
  assign trigger_start_enable = timer_control_one[`C1_TRIGGER_START_ENABLE];

  function automatic logic sel_wr(input logic [11:0] off);
    sel_wr = wr_acc && (paddr == off);
  endfunction

  // ==========================================
  // pin synchronisers, three stages
  logic [2:0] eck_s;
  logic [2:0] ecl_s;
  logic [2:0] trg_s;
  logic       eck_l;
  logic       ecl_l;
  logic       trg_l;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      eck_s <= 3'h0;
      ecl_s <= 3'h0;
      trg_s <= 3'h0;
    end
    else
    begin
      eck_s <= {eck_s[1:0], ext_clock_pin};
      ecl_s <= {ecl_s[1:0], ext_clear_pin};
      trg_s <= {trg_s[1:0], start_trigger_pin};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      eck_l <= 1'b0;
      ecl_l <= 1'b0;
      trg_l <= 1'b0;
    end
    else
    begin
      if (eck_s[1] == eck_s[2]) eck_l <= eck_s[2];
      if (ecl_s[1] == ecl_s[2]) ecl_l <= ecl_s[2];
      if (trg_s[1] == trg_s[2]) trg_l <= trg_s[2];
    end
  end

  logic eck_rise;
  logic eck_fall;
  logic ecl_rise;
  logic trg_rise;
  logic trg_fall;

  assign eck_rise = (eck_s[1] == eck_s[2]) & eck_s[2] & ~eck_l;
  assign eck_fall = (eck_s[1] == eck_s[2]) & ~eck_s[2] & eck_l;
  assign ecl_rise = (ecl_s[1] == ecl_s[2]) & ecl_s[2] & ~ecl_l;
  assign trg_rise = (trg_s[1] == trg_s[2]) & trg_s[2] & ~trg_l;
  assign trg_fall = (trg_s[1] == trg_s[2]) & ~trg_s[2] & trg_l;

  // ==========================================
  // prescaler and clock select
  logic [`PRE_WIDTH-1:0] pre_cnt;
  logic [`PRE_WIDTH-1:0] pre_prev;
  logic                  tick;
  logic [2:0]            div_bit;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 1'b1;
  end

  assign pre_prev = pre_cnt - 1'b1;

  // divide by 2^(2*sel+extra): 2*sel-1+extra is bit index of falling prescaler stage
  always_comb
  begin
    div_bit = {clk_sel[1:0], 1'b0} - 3'h1 + {2'h0, internal_clock_extra_select};
    tick    = 1'b0;
    unique case (clk_sel)
      3'b001, 3'b010, 3'b011:
        tick = pre_prev[div_bit] & ~pre_cnt[div_bit];
      3'b101:  tick = eck_rise;
      3'b110:  tick = eck_fall;
      3'b111:  tick = eck_rise | eck_fall;
      3'b000, 3'b100: tick = 1'b0;
    endcase
  end

  // ==========================================
  // compare and clear
  logic match_a;
  logic match_b;
  logic clr_ev;
  logic trig_ev;
  logic write_a_now;
  logic eq_a;
  logic eq_b;
  logic eq_a_q;
  logic eq_b_q;

  assign write_a_now = psel & pwrite & (paddr == `OFF_CMP_A);
  assign eq_a    = (count_value == compare_value_a) & ~write_a_now;
  assign eq_b    = (count_value == compare_value_b);
  // one match per arrival: a stopped count must not toggle every cycle
  assign match_a = eq_a & ~eq_a_q;
  assign match_b = eq_b & ~eq_b_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      eq_a_q <= 1'b0;
      eq_b_q <= 1'b0;
    end
    else
    begin
      eq_a_q <= eq_a;
      eq_b_q <= eq_b;
    end
  end

  always_comb
  begin
    unique case (clear_sel)
      2'b01:   clr_ev = match_a;
      2'b10:   clr_ev = match_b;
      2'b11:   clr_ev = ecl_rise;
      2'b00:   clr_ev = 1'b0;
    endcase
  end

  assign trig_ev = (trig_edge[0] & trg_rise) | (trig_edge[1] & trg_fall);

  // ==========================================
  // run control
  run_state_t run_state;
  run_state_t next_run_state;
  logic       running;

  always_comb
  begin
    next_run_state = run_state;
    unique case (run_state)
      RUN_IDLE:
        next_run_state = trigger_start_enable ? RUN_WAIT : RUN_COUNT;
      RUN_COUNT:
        if (trigger_start_enable && clr_ev && clear_sel != 2'b00)
          next_run_state = RUN_HALT;
      RUN_HALT, RUN_WAIT:
        if (!trigger_start_enable)
          next_run_state = RUN_COUNT;
        else if (trig_ev)
          next_run_state = RUN_COUNT;
      default: next_run_state = RUN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      run_state <= RUN_IDLE;
    else
      run_state <= next_run_state;
  end

  assign running = (run_state == RUN_COUNT);

  // ==========================================
  // counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      count_value <= `RST_COUNT;
    else if (sel_wr(`OFF_COUNT))
      count_value <= wbyte;
    else if (clr_ev)
      count_value <= 8'h00;
    else if (tick && running)
      count_value <= count_value + 8'h01;
  end

  // ==========================================
  // compare and control registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      compare_value_a    <= `RST_CMP;
      compare_value_b    <= `RST_CMP;
      timer_control_zero <= `RST_CTRL0;
      timer_control_one  <= `RST_CTRL1;
      out_sel            <= 4'h0;
    end
    else
    begin
      if (sel_wr(`OFF_CMP_A)) compare_value_a <= wbyte;
      if (sel_wr(`OFF_CMP_B)) compare_value_b <= wbyte;
      if (sel_wr(`OFF_CTRL0)) timer_control_zero <= wbyte;
      if (sel_wr(`OFF_CTRL1)) timer_control_one <= {3'h0, wbyte[4:0]};
      if (sel_wr(`OFF_FLAGS)) out_sel <= wbyte[3:0];
    end
  end

  // ==========================================
  // flags: set wins over clear
  logic ov_ev;
  logic [2:0] next_flags;
  logic [2:0] cur_flags;

  assign ov_ev     = tick & running & (count_value == 8'hff) &
                     ~sel_wr(`OFF_COUNT) & ~clr_ev;
  assign cur_flags = {match_b_flag, match_a_flag, overflow_flag};

  always_comb
  begin
    next_flags = cur_flags;
    if (sel_wr(`OFF_FLAGS))
      next_flags = cur_flags & ~(flag_seen & ~wbyte[7:5]);
    if (ov_ev) next_flags[0] = 1'b1;
    if (match_a) next_flags[1] = 1'b1;
    if (match_b) next_flags[2] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      {match_b_flag, match_a_flag, overflow_flag} <= 3'h0;
      flag_seen <= 3'h0;
    end
    else
    begin
      {match_b_flag, match_a_flag, overflow_flag} <= next_flags;
      if (rd_acc && paddr == `OFF_FLAGS)
        flag_seen <= cur_flags;
      else if (sel_wr(`OFF_FLAGS))
        flag_seen <= 3'h0;
    end
  end

  // ==========================================
  // waveform output
  function automatic logic out_act(input logic [1:0] act, input logic cur);
    unique case (act)
      2'b01:   out_act = 1'b0;
      2'b10:   out_act = 1'b1;
      2'b11:   out_act = ~cur;
      2'b00:   out_act = cur;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      wave_out_pin <= 1'b0;
    else
      wave_out_pin <= match_b ? out_act(out_sel[3:2],
                        match_a ? out_act(out_sel[1:0], wave_out_pin)
                                : wave_out_pin)
                    : (match_a ? out_act(out_sel[1:0], wave_out_pin)
                               : wave_out_pin);
  end

  // ==========================================
  // interrupt request and read data
  // enables a, b and overflow
  assign irq_request = (match_a_flag & timer_control_zero[`C0_IEA]) |
                       (match_b_flag & timer_control_zero[`C0_IEB]) |
                       (overflow_flag & timer_control_zero[`C0_IEO]);

  byte_t rd_byte;
  always_comb
  begin
    unique case (paddr)
      `OFF_COUNT: rd_byte = count_value;
      `OFF_CMP_A: rd_byte = compare_value_a;
      `OFF_CMP_B: rd_byte = compare_value_b;
      `OFF_CTRL0: rd_byte = timer_control_zero;
      `OFF_FLAGS: rd_byte = {cur_flags, 1'b0, out_sel} | `FL_RSV_ONE;
      `OFF_CTRL1: rd_byte = timer_control_one | `C1_RSV_ONES;
      default:    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (rd_acc)
      prdata <= {24'h00_0000, rd_byte};
  end

  // ==========================================
  // checks
  property p_cnt_reset;
    @(posedge clk_sys) $rose(resetn) |-> count_value == 8'h00;
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("count not zero");

  property p_cnt_write;
    @(posedge clk_sys) disable iff (!resetn)
      (wr_acc && paddr == `OFF_COUNT) |=> count_value == $past(wbyte);
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

  property p_ovf_set;
    @(posedge clk_sys) disable iff (!resetn) ov_ev |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  property p_match_a;
    @(posedge clk_sys) disable iff (!resetn) match_a |=> match_a_flag;
  endproperty
  a_match_a: assert property (p_match_a) else $error("match a lost");

  property p_match_b;
    @(posedge clk_sys) disable iff (!resetn) match_b |=> match_b_flag;
  endproperty
  a_match_b: assert property (p_match_b) else $error("match b lost");

  property p_irq;
    @(posedge clk_sys) disable iff (!resetn)
      (match_a_flag && timer_control_zero[`C0_IEA]) |-> irq_request;
  endproperty
  a_irq: assert property (p_irq) else $error("irq a missing");

  property p_stop;
    @(posedge clk_sys) disable iff (!resetn)
      (clk_sel[1:0] == 2'b00 && !(wr_acc && paddr == `OFF_COUNT) && !clr_ev)
        |=> $stable(count_value);
  endproperty
  a_stop: assert property (p_stop) else $error("counted while stopped");

  property p_flag_hold;
    @(posedge clk_sys) disable iff (!resetn)
      (overflow_flag && !(wr_acc && paddr == `OFF_FLAGS)) |=> overflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
endmodule
`default_nettype wire

// file: event_timer_pins.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// pin sources: one pulse per request, idle low
module event_timer_pins
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [1:0] pin_sel,
  output logic            ext_clock_pin,
  output logic            ext_clear_pin,
  output logic            start_trigger_pin,
  output logic            busy
);
  logic [4:0] t;
  logic [1:0] s;
  logic       lvl;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      t <= 5'h00;
      s <= 2'h0;
    end
    else if (go && t == 5'h00)
    begin
      t <= 5'h1f;
      s <= pin_sel;
    end
    else if (t != 5'h00)
      t <= t - 5'h01;
  end
  // 16 high, 15 low: well past the sync delay
  assign lvl               = t >= 5'h10;
  assign ext_clock_pin     = lvl && s == 2'h0;
  assign ext_clear_pin     = lvl && s == 2'h1;
  assign start_trigger_pin = lvl && s == 2'h2;
  assign busy              = t != 5'h00;
endmodule
`default_nettype wire

// file: event_timer_compare_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "event_timer_defs.svh"
module event_timer_compare_tb_top;
  import event_timer_pkg::*;
  logic        clk_sys = 0, resetn = 0, go = 0, m_wave = 0;
  logic        psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hb51868c2;
  logic        pready, pslverr, wave_out_pin, irq_request, busy;
  logic        ext_clock_pin, ext_clear_pin, start_trigger_pin;
  logic [1:0]  pin_sel = 2'h0;
  int          n_fail = 0, checks_done = 0, m_cnt = 0, m_a = 255;
  int          m_b = 255, m_flg = 0, m_seen = 0, m_clr = 0, m_osa = 0;
  int          m_trigger_start_enable = 0, m_halt = 0, i;
  int          modes[5] = '{0, 4, 5, 6, 7};
  int          incs[5] = '{0, 0, 1, 1, 2};
  int          ens[4] = '{32, 64, 128, 0};
  always #5 clk_sys = ~clk_sys;
  event_timer_compare event_timer_compare_inst (.clk_sys(clk_sys),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
    .ext_clear_pin(ext_clear_pin), .start_trigger_pin(start_trigger_pin),
    .wave_out_pin(wave_out_pin), .irq_request(irq_request));
  event_timer_pins event_timer_pins_inst (.clk_sys(clk_sys),
    .resetn(resetn), .go(go), .pin_sel(pin_sel), .busy(busy),
    .ext_clock_pin(ext_clock_pin), .ext_clear_pin(ext_clear_pin),
    .start_trigger_pin(start_trigger_pin));
  // ====================
  // reporting
  task results;
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // ====================
  // apb master, waits on pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h0, d});
    case (a)
      `OFF_COUNT: m_cnt = d;
      `OFF_CMP_A: m_a = d;
      `OFF_CMP_B: m_b = d;
      `OFF_CTRL0: m_clr = d[4:3];
      `OFF_CTRL1: m_trigger_start_enable = d[2];
      `OFF_FLAGS:
      begin
        m_osa = d[1:0];
        m_flg = m_flg & ~(m_seen & ~d & 8'he0);
        m_seen = 0;
      end
      default: ;
    endcase
  endtask
  task rdchk(input string nm, input logic [11:0] a, input int exp);
    apb(0, a, 32'h0);
    if (a == `OFF_FLAGS)
      m_seen = m_flg;
    chk(nm, rd, exp);
  endtask
  // ====================
  // reference counter, one call per counted edge
  task step;
    if (m_halt == 0)
    begin
      m_cnt = (m_cnt + 1) % 256;
      if (m_cnt == 0)
        m_flg |= 32;
      if (m_cnt == m_b)
        m_flg |= 128;
      if (m_cnt == m_a)
      begin
        m_flg |= 64;
        if (m_osa == 1)
          m_wave = 0;
        else if (m_osa == 2)
          m_wave = 1;
        else if (m_osa == 3)
          m_wave = !m_wave;
        if (m_clr == 1)
        begin
          m_cnt = 0;
          m_halt = m_trigger_start_enable;
        end
      end
    end
  endtask
  task pulse(input logic [1:0] s, input int inc);
    int n;
    @(posedge clk_sys);
    go <= 1;
    pin_sel <= s;
    @(posedge clk_sys);
    go <= 0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (busy !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      n_fail++;
      results();
    end
    repeat (8) @(posedge clk_sys);
    repeat (inc) step();
  endtask
  // ====================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1;
    chk("wave", wave_out_pin, 0);
    rdchk("count", `OFF_COUNT, 0);
    rdchk("cmp_a", `OFF_CMP_A, 255);
    rdchk("cmp_b", `OFF_CMP_B, 255);
    rdchk("flags", `OFF_FLAGS, 16);
    rdchk("ctrl1", `OFF_CTRL1, 224);
    // random values kept apart so no match fires
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(`OFF_COUNT, seed[7:0] & 8'h3f);
      rdchk("count", `OFF_COUNT, m_cnt);
      wr(`OFF_CMP_B, seed[15:8] | 8'h80);
      rdchk("cmp_b", `OFF_CMP_B, m_b);
    end
    apb(0, 12'h020, 32'h0);
    chk("slverr", err, 1);
    chk("unmapped", rd, 0);
    wr(`OFF_CTRL0, 8'h01);
    repeat (40) @(posedge clk_sys);
    wr(`OFF_CTRL0, 8'h00);
    apb(0, `OFF_COUNT, 32'h0);
    // prescaler phase unknown, so a window
    chk("div4", rd >= m_cnt + 9 && rd <= m_cnt + 12, 1);
    wr(`OFF_CMP_B, 8'hff);
    wr(`OFF_COUNT, 8'h10);
    for (i = 0; i < 5; i++)
    begin
      wr(`OFF_CTRL0, modes[i]);
      pulse(0, incs[i]);
      rdchk("count", `OFF_COUNT, m_cnt);
    end
    wr(`OFF_CTRL0, 8'h25);
    wr(`OFF_COUNT, 8'hfe);
    pulse(0, 1);
    pulse(0, 1);
    chk("irq", irq_request, 1);
    for (i = 0; i < 4; i++)
    begin
      wr(`OFF_CTRL0, ens[i] | 5);
      @(negedge clk_sys);
      chk("irq", irq_request, (ens[i] & m_flg) != 0);
    end
    wr(`OFF_FLAGS, 8'h00);
    rdchk("flags", `OFF_FLAGS, m_flg | 16);
    wr(`OFF_FLAGS, 8'h00);
    rdchk("flags", `OFF_FLAGS, 16);
    chk("irq", irq_request, 0);
    wr(`OFF_CMP_A, 8'h03);
    wr(`OFF_COUNT, 8'h00);
    wr(`OFF_FLAGS, 8'h03);
    wr(`OFF_CTRL0, 8'h0d);
    repeat (5) pulse(0, 1);
    rdchk("count", `OFF_COUNT, m_cnt);
    chk("wave", wave_out_pin, m_wave);
    rdchk("flags", `OFF_FLAGS, m_flg | 16 | m_osa);
    wr(`OFF_CTRL1, 8'h0c);
    pulse(2, 0);
    repeat (3) pulse(0, 1);
    rdchk("count", `OFF_COUNT, m_cnt);
    pulse(2, 0);
    m_halt = 0;
    repeat (2) pulse(0, 1);
    rdchk("count", `OFF_COUNT, m_cnt);
    wr(`OFF_CTRL0, 8'h1d);
    wr(`OFF_CTRL1, 8'h00);
    pulse(1, 0);
    m_cnt = 0;
    rdchk("count", `OFF_COUNT, m_cnt);
    results();
  end
endmodule
`default_nettype wire
